// ==== dv/reset_sequence_and_supply_warning_test.sv ====
`timescale 1ns/100ps
module reset_sequence_and_supply_warning_test;
   import rssw_pkg::*;
   logic mclk = 0, rst = 1, opt_long = 0, opt_lsd = 1, pin, pin_o, pin_oe;
   logic lsd = 0, wdg = 0, cmp_lvl = 0, tool = 0, app_en, core_rst, vfetch, irq;
   logic psel = 0, pen = 0, pwr = 0, pready, pslverr, err, ext_pull = 0, tool_rst = 0;
   logic [15:0] vaddr;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, prior;
   int errors = 0, checked = 0, seed = 32'h0FB4, exp_flag = 0;
   rssw_reset_seq dut_u (.I_MCLK(mclk), .I_RST(rst), .I_OPT_LONG_DELAY(opt_long),
      .I_OPT_LSD_EN(opt_lsd), .I_RST_PIN_I(pin), .O_RST_PIN_O(pin_o), .O_RST_PIN_OE(pin_oe),
      .I_LSD_TRIP(lsd), .I_WDG_RST(wdg), .I_SUPPLY_CMP(cmp_lvl), .I_INCIRCUIT_PROG_TOOL(tool),
      .O_INCIRCUIT_PINS_APP_EN(app_en), .O_CORE_RST(core_rst), .O_VEC_FETCH(vfetch),
      .O_VEC_ADDR(vaddr), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_IRQ(irq));
   rssw_far_model far_u (.i_dev_oe(pin_oe), .i_dev_o(pin_o), .i_ext_pull(ext_pull),
      .i_tool_rst(tool_rst), .o_pin(pin));
   initial begin
      forever #25 mclk = ~mclk;
   end
   // ----
   // helpers
   // ----
   task close_out;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   task tmo;
      errors++;
      $display("Error %0t: wait ran out", $time);
      close_out();
   endtask : tmo
   task cmp_v(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : cmp_v
   task tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1;
      pen <= 0;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      pen <= 1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
   endtask : apb
   task wr_en(input logic en);
      apb(1, OFF_SYSTEM_INTEGRITY_CTRL_STATUS, (32'($random(seed)) & 32'hFFFFFFFB) | (32'(en) << 2));
   endtask : wr_en
   task set_cmp(input logic v);
      @(posedge mclk);
      if (opt_lsd && cmp_lvl !== v) exp_flag ^= 1;
      cmp_lvl <= v;
      tick(4);
   endtask : set_cmp
   task chk_si(input logic en);
      apb(0, OFF_SYSTEM_INTEGRITY_CTRL_STATUS, 0);
      cmp_v(rd & 32'h7, {29'h0, en, exp_flag[0], cmp_lvl & opt_lsd}, "system_integrity_ctrl_status");
   endtask : chk_si
   task chk_stat(input logic [31:0] e);
      apb(0, OFF_IRQ_STAT, 0);
      cmp_v(rd, e, "irq stat");
   endtask : chk_stat
   task pulse_wdg;
      @(posedge mclk);
      wdg <= 1;
      @(posedge mclk);
      wdg <= 0;
   endtask : pulse_wdg
   task run_seq(input int ec, input int eo);
      int nc, no, n;
      logic [15:0] q[$];
      nc = 0;
      no = 0;
      n = 0;
      q = '{VEC_LO, VEC_HI};
      @(negedge mclk);
      while (vfetch !== 1'b1) begin
         nc += int'(core_rst === 1'b1);
         no += int'(pin_oe === 1'b1);
         if (++n > 6000) tmo();
         @(negedge mclk);
      end
      while (q.size() > 0) begin
         cmp_v(vfetch, 1, "fetch");
         cmp_v(vaddr, q.pop_front(), "vector");
         @(negedge mclk);
      end
      cmp_v({vfetch, core_rst, pin_oe}, 0, "end");
      if (ec >= 0) cmp_v(nc, ec, "core count");
      cmp_v(no, eo >= 0 ? eo : nc, "pin low count");
      tick(8);
   endtask : run_seq
   task chk_src(input logic [31:0] e);
      apb(0, OFF_SYSTEM_INTEGRITY_CTRL_STATUS, 0);
      cmp_v(rd & 32'h38, e, "source");
   endtask : chk_src
   // ----
   // main sequence
   // ----
   initial begin
      tick(2);
      rst <= 0;
      tick(1);
      cmp_v({pin_oe, core_rst, vfetch, irq, vaddr}, {4'h0, VEC_LO}, "idle");
      apb(0, OFF_SYSTEM_INTEGRITY_CTRL_STATUS, 0);
      cmp_v(rd & 32'hC0, 32'h80, "options");
      apb(0, 8'h0C, 0);
      cmp_v(err, 1, "unmapped err");
      cmp_v(rd, 0, "unmapped data");
      pulse_wdg();
      run_seq(272, 272);
      chk_src(32'h20);
      apb(1, OFF_IRQ_MASK, 32'h2);
      tick(1);
      cmp_v(irq, 1, "done irq");
      chk_stat(2);
      tick(1);
      cmp_v(irq, 0, "irq clear");
      @(posedge mclk);
      lsd <= 1;
      tick(20 + ($unsigned($random(seed)) % 16));
      lsd <= 0;
      run_seq(-1, -1);
      chk_src(32'h10);
      @(posedge mclk);
      lsd <= 1;
      tick(10);
      lsd <= 0;
      tick(100);
      pulse_wdg();
      run_seq(272, 272);
      @(posedge mclk);
      ext_pull <= 1;
      tick(5 + ($unsigned($random(seed)) % 8));
      ext_pull <= 0;
      run_seq(-1, 256);
      chk_src(32'h08);
      tool <= 1;
      tick(4);
      cmp_v(app_en, 0, "tool pins");
      tool_rst <= 1;
      tick(6);
      tool_rst <= 0;
      run_seq(-1, 256);
      chk_src(32'h08);
      tool <= 0;
      tick(4);
      cmp_v(app_en, 1, "app pins");
      apb(1, OFF_IRQ_MASK, 32'h3);
      chk_stat(2);
      set_cmp(1);
      chk_si(0);
      chk_stat(0);
      wr_en(0);
      chk_si(0);
      set_cmp(0);
      wr_en(1);
      tick(3);
      cmp_v(irq, 1, "aux irq");
      chk_stat(1);
      set_cmp(1);
      chk_si(1);
      chk_stat(1);
      set_cmp(0);
      chk_stat(1);
      wr_en(0);
      set_cmp(1);
      chk_stat(0);
      wr_en(1);
      tick(3);
      chk_stat(1);
      chk_stat(0);
      set_cmp(0);
      chk_stat(1);
      pulse_wdg();
      tick(50);
      cmp_lvl <= 1;
      run_seq(222, 222);
      chk_stat(2);
      chk_si(1);
      @(posedge mclk);
      rst <= 1;
      opt_lsd <= 0;
      opt_long <= 1;
      tick(3);
      rst <= 0;
      apb(0, OFF_SYSTEM_INTEGRITY_CTRL_STATUS, 0);
      cmp_v(rd & 32'hC0, 32'h40, "options");
      prior = rd;
      set_cmp(0);
      apb(0, OFF_SYSTEM_INTEGRITY_CTRL_STATUS, 0);
      cmp_v(rd & 32'h3, prior & 32'h2, "aux off");
      wr_en(1);
      tick(3);
      chk_stat(0);
      pulse_wdg();
      run_seq(4112, 4112);
      close_out();
   end
endmodule : reset_sequence_and_supply_warning_test

// ==== dv/rssw_far_model.sv ====
`timescale 1ns/100ps
module rssw_far_model (
   // device drive
   input wire logic i_dev_oe,
   input wire logic i_dev_o,
   // outside parties
   input wire logic i_ext_pull,
   input wire logic i_tool_rst,
   // resolved pin
   output logic o_pin
);
   // ----
   // open-drain wire with weak pull-up
   // ----
   assign o_pin = ~(i_ext_pull | i_tool_rst) & (i_dev_oe ? i_dev_o : 1'b1);
endmodule : rssw_far_model

// ==== logic/rssw_pkg.sv ====
// Contract
// - External pin, low supply detector and watchdog each start the reset sequence.
// - Every source acts on the reset pin; pin held low through the delay phase.
// - Phases run in order: active, stabilisation delay, reset vector fetch.
// - Delay counts clock cycles: 4096 or 256, chosen by the option setting.
// - Vector fetch phase lasts exactly two clock cycles after the delay.
// - Start address comes from the fixed two-byte vector at the top of memory.
// - Reset pin is an input and an open-drain output driven low during reset.
// - Low level on the reset pin is caught without the clock.
// - Comparator output readable as a read-only real-time status bit.
// - Aux supply monitor works only when the low supply detector option is set.
// - With interrupt enabled, each comparator change interrupts; the flag toggles. Here changes while the sequence runs are absorbed: no interrupt, no toggle.
// - Rising crossing inside the reset delay gives no aux interrupt.
// - Enable before a slow rising crossing gives two interrupts: enable and crossing.
// - Enable after the rising crossing gives exactly one interrupt for that rise.
// - While the tool is attached, in-circuit clock and data pins leave the application.
package rssw_pkg;
   // -------------------------------------------------------------
   // widths
   // -------------------------------------------------------------
   localparam int APB_DW = 32;
   localparam int CNT_W = 13;
   localparam int VEC_W = 16;
   // -------------------------------------------------------------
   // cycle counts
   // -------------------------------------------------------------
   localparam logic [CNT_W-1:0] DLY_LONG_CYC = 13'h1000;
   localparam logic [CNT_W-1:0] DLY_SHORT_CYC = 13'h0100;
   localparam logic [CNT_W-1:0] FETCH_CYC = 13'h0002;
   localparam logic [CNT_W-1:0] WDG_ACT_CYC = 13'h0010;
   localparam logic [CNT_W-1:0] GUARD_CYC = 13'h0004;
   // -------------------------------------------------------------
   // reset vector
   // -------------------------------------------------------------
   localparam logic [VEC_W-1:0] VEC_LO = 16'hFFFE;
   localparam logic [VEC_W-1:0] VEC_HI = 16'hFFFF;
   // -------------------------------------------------------------
   // register offsets and fields
   // -------------------------------------------------------------
   localparam logic [7:0] OFF_SYSTEM_INTEGRITY_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
   localparam int SI_LEVEL_BIT = 0;
   localparam int SI_FLAG_BIT = 1;
   localparam int SI_IRQEN_BIT = 2;
   localparam int SI_SRC_LSB = 3;
   localparam int SI_OPT_LONG_BIT = 6;
   localparam int SI_OPT_LSD_BIT = 7;
   localparam int IRQ_AUX_BIT = 0;
   localparam int IRQ_DONE_BIT = 1;
   localparam int IRQ_W = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
   localparam logic SI_IRQEN_RST = 1'b0;
   // synchroniser order: ext latch, pin, lsd trip, comparator, tool
   localparam int SYNC_W = 5;
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h08;
   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_DELAY = 2'b10,
      ST_FETCH = 2'b11
   } rssw_state_t;
   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_EXT = 3'b001,
      SRC_LSD = 3'b010,
      SRC_WDG = 3'b100
   } rssw_src_t;
endpackage : rssw_pkg

// ==== logic/rssw_reset_seq.sv ====
`timescale 1ns/100ps
module rssw_reset_seq #(
   parameter int PADDR_W = 8
) (
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST,
   // option settings
   input wire logic I_OPT_LONG_DELAY,
   input wire logic I_OPT_LSD_EN,
   // reset pin and sources
   input wire logic I_RST_PIN_I,
   output logic O_RST_PIN_O,
   output logic O_RST_PIN_OE,
   input wire logic I_LSD_TRIP,
   input wire logic I_WDG_RST,
   // supply comparator
   input wire logic I_SUPPLY_CMP,
   // programming tool
   input wire logic I_INCIRCUIT_PROG_TOOL,
   output logic O_INCIRCUIT_PINS_APP_EN,
   // core side
   output logic O_CORE_RST,
   output logic O_VEC_FETCH,
   output logic [rssw_pkg::VEC_W-1:0] O_VEC_ADDR,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [PADDR_W-1:0] I_PADDR,
   input wire logic [rssw_pkg::APB_DW-1:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic [rssw_pkg::APB_DW-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // interrupt
   output logic O_IRQ
);
   import rssw_pkg::*;

   rssw_state_t st_reg;
   rssw_src_t src_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] guard_reg;
   logic [CNT_W-1:0] dly_len;
   logic ext_latch_reg;
   logic [SYNC_W-1:0] sync_q;
   logic ext_sync, pin_sync, lsd_sync, cmp_sync, tool_sync;
   logic lsd_prev_reg, opt_long_reg, opt_lsd_reg;
   logic lsd_lvl, lsd_rise, ext_req, restart, start, seq_done;
   logic act_end;
   logic vec_fetch_reg;
   logic [VEC_W-1:0] vec_addr_reg;
   logic cmp_prev_reg, flag_reg, irq_en_reg, irq_en_prev_reg;
   logic cmp_change, en_rise, aux_ev;
   logic [IRQ_W-1:0] stat_reg, mask_reg, stat_set;
   logic [2:0] last_src_reg;
   logic [7:0] off;
   logic acc, rd_acc, wr_acc, hit, setup_rd;
   logic [7:0] system_integrity_ctrl_status_val;

   // -------------------------------------------------------------
   // option capture at reset
   // -------------------------------------------------------------
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         opt_long_reg <= I_OPT_LONG_DELAY;
         opt_lsd_reg <= I_OPT_LSD_EN;
      end
   end

   // -------------------------------------------------------------
   // pin capture without clock
   // -------------------------------------------------------------
   // pin low sets the latch even with the clock stopped
   always_ff @(posedge I_MCLK or negedge I_RST_PIN_I) begin
      if (!I_RST_PIN_I) begin
         ext_latch_reg <= 1'b1;
      end else if (I_RST || st_reg != ST_IDLE || guard_reg != '0) begin
         ext_latch_reg <= 1'b0;
      end
   end

   rssw_sync2 #(
      .W(SYNC_W),
      .RST_VAL(SYNC_RST)
   ) u_sync (
      .i_clk(I_MCLK),
      .i_rst(I_RST),
      .i_async({ext_latch_reg, I_RST_PIN_I, I_LSD_TRIP, I_SUPPLY_CMP, I_INCIRCUIT_PROG_TOOL}),
      .o_sync(sync_q)
   );
   assign {ext_sync, pin_sync, lsd_sync, cmp_sync, tool_sync} = sync_q;
   // -------------------------------------------------------------
   // source qualification
   // -------------------------------------------------------------
   assign lsd_lvl = lsd_sync & opt_lsd_reg;
   assign lsd_rise = lsd_lvl & ~lsd_prev_reg;
   // own pin drive is not mistaken for an outside reset
   assign ext_req = ext_sync & (guard_reg == '0);
   assign restart = (st_reg != ST_IDLE) & (lsd_rise | I_WDG_RST);
   assign start = ((st_reg == ST_IDLE) & (ext_req | lsd_lvl | I_WDG_RST)) | restart;
   assign dly_len = opt_long_reg ? DLY_LONG_CYC : DLY_SHORT_CYC;
   always_comb begin
      case (src_reg)
         SRC_EXT: act_end = pin_sync;
         SRC_LSD: act_end = ~lsd_lvl;
         SRC_WDG: act_end = (cnt_reg == WDG_ACT_CYC - 13'h0001);
         default: act_end = 1'b1;
      endcase
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         lsd_prev_reg <= 1'b0;
      end else begin
         lsd_prev_reg <= lsd_lvl;
      end
   end

   // -------------------------------------------------------------
   // sequence state machine
   // -------------------------------------------------------------
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         st_reg <= ST_IDLE;
         src_reg <= SRC_NONE;
         cnt_reg <= '0;
      end else if (start) begin
         st_reg <= ST_ACTIVE;
         cnt_reg <= '0;
         if (lsd_lvl) begin
            src_reg <= SRC_LSD;
         end else if (I_WDG_RST) begin
            src_reg <= SRC_WDG;
         end else begin
            src_reg <= SRC_EXT;
         end
      end else begin
         case (st_reg)
            ST_ACTIVE: begin
               cnt_reg <= act_end ? '0 : cnt_reg + 13'h0001;
               if (act_end) begin
                  st_reg <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               cnt_reg <= (cnt_reg == dly_len - 13'h0001) ? '0 : cnt_reg + 13'h0001;
               if (cnt_reg == dly_len - 13'h0001) begin
                  st_reg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               cnt_reg <= (cnt_reg == FETCH_CYC - 13'h0001) ? '0 : cnt_reg + 13'h0001;
               if (cnt_reg == FETCH_CYC - 13'h0001) begin
                  st_reg <= ST_IDLE;
               end
            end
            default: begin
               st_reg <= ST_IDLE;
               cnt_reg <= '0;
            end
         endcase
      end
   end

   assign seq_done = (st_reg == ST_FETCH) & (cnt_reg == FETCH_CYC - 13'h0001) & ~start;
   // pin rises on the pull-up after release; ignore it for a few cycles
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         guard_reg <= '0;
      end else if (seq_done) begin
         guard_reg <= GUARD_CYC;
      end else if (guard_reg != '0) begin
         guard_reg <= guard_reg - 13'h0001;
      end
   end

   // -------------------------------------------------------------
   // vector fetch
   // -------------------------------------------------------------
   always_ff @(posedge I_MCLK) begin
      if (I_RST || start) begin
         vec_fetch_reg <= 1'b0;
         vec_addr_reg <= VEC_LO;
      end else if (st_reg == ST_DELAY && cnt_reg == dly_len - 13'h0001) begin
         vec_fetch_reg <= 1'b1;
         vec_addr_reg <= VEC_LO;
      end else if (st_reg == ST_FETCH && cnt_reg == '0) begin
         vec_addr_reg <= VEC_HI;
      end else if (seq_done) begin
         vec_fetch_reg <= 1'b0;
         vec_addr_reg <= VEC_LO;
      end
   end

   // -------------------------------------------------------------
   // pin and core outputs
   // -------------------------------------------------------------
   // open drain: only ever pulls low
   assign O_RST_PIN_O = 1'b0;
   assign O_RST_PIN_OE = (st_reg == ST_DELAY) | (st_reg == ST_ACTIVE && src_reg != SRC_EXT);
   assign O_CORE_RST = (st_reg == ST_ACTIVE) | (st_reg == ST_DELAY);
   assign O_VEC_FETCH = vec_fetch_reg;
   assign O_VEC_ADDR = vec_addr_reg;
   assign O_INCIRCUIT_PINS_APP_EN = ~tool_sync;

   // -------------------------------------------------------------
   // aux supply monitor
   // -------------------------------------------------------------
   // crossings inside the sequence are absorbed
   assign cmp_change = opt_lsd_reg & (st_reg == ST_IDLE) & (cmp_sync != cmp_prev_reg);
   assign en_rise = irq_en_reg & ~irq_en_prev_reg;
   assign aux_ev = opt_lsd_reg & ((cmp_change & irq_en_reg) | en_rise);
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         cmp_prev_reg <= 1'b0;
         flag_reg <= 1'b0;
         irq_en_prev_reg <= SI_IRQEN_RST;
      end else begin
         cmp_prev_reg <= cmp_sync;
         irq_en_prev_reg <= irq_en_reg;
         if (cmp_change) begin
            flag_reg <= ~flag_reg;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         last_src_reg <= SRC_NONE;
      end else if (start) begin
         last_src_reg <= lsd_lvl ? SRC_LSD : (I_WDG_RST ? SRC_WDG : SRC_EXT);
      end
   end

   // -------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------
   assign off = 8'(I_PADDR);
   assign acc = I_PSEL & I_PENABLE;
   assign hit = (off == OFF_SYSTEM_INTEGRITY_CTRL_STATUS) | (off == OFF_IRQ_STAT) | (off == OFF_IRQ_MASK);
   assign rd_acc = acc & ~I_PWRITE;
   assign wr_acc = acc & I_PWRITE & I_PSTRB[0];
   assign setup_rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = acc & ~hit;
   always_comb begin
      system_integrity_ctrl_status_val = '0;
      system_integrity_ctrl_status_val[SI_LEVEL_BIT] = opt_lsd_reg & cmp_sync;
      system_integrity_ctrl_status_val[SI_FLAG_BIT] = flag_reg;
      system_integrity_ctrl_status_val[SI_IRQEN_BIT] = irq_en_reg;
      system_integrity_ctrl_status_val[SI_SRC_LSB +: 3] = last_src_reg;
      system_integrity_ctrl_status_val[SI_OPT_LONG_BIT] = opt_long_reg;
      system_integrity_ctrl_status_val[SI_OPT_LSD_BIT] = opt_lsd_reg;
   end

   // read data prepared in the setup cycle
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         O_PRDATA <= '0;
      end else if (setup_rd) begin
         case (off)
            OFF_SYSTEM_INTEGRITY_CTRL_STATUS: O_PRDATA <= {24'h000000, system_integrity_ctrl_status_val};
            OFF_IRQ_STAT: O_PRDATA <= {30'h00000000, stat_reg};
            OFF_IRQ_MASK: O_PRDATA <= {30'h00000000, mask_reg};
            default: O_PRDATA <= '0;
         endcase
      end
   end

   // only the enable bit is writable in the status register
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         irq_en_reg <= SI_IRQEN_RST;
         mask_reg <= IRQ_MASK_RST;
      end else if (wr_acc) begin
         if (off == OFF_SYSTEM_INTEGRITY_CTRL_STATUS) begin
            irq_en_reg <= I_PWDATA[SI_IRQEN_BIT];
         end
         if (off == OFF_IRQ_MASK) begin
            mask_reg <= I_PWDATA[IRQ_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------
   // interrupt status, clear on read, set wins
   // -------------------------------------------------------------
   always_comb begin
      stat_set = '0;
      stat_set[IRQ_AUX_BIT] = aux_ev;
      stat_set[IRQ_DONE_BIT] = seq_done;
   end
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         stat_reg <= '0;
      end else if (rd_acc && off == OFF_IRQ_STAT) begin
         stat_reg <= stat_set;
      end else begin
         stat_reg <= stat_reg | stat_set;
      end
   end

   assign O_IRQ = |(stat_reg & mask_reg);
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   logic [CNT_W-1:0] dly_run_reg;
   always_ff @(posedge I_MCLK) begin
      if (I_RST || st_reg != ST_DELAY) begin
         dly_run_reg <= '0;
      end else begin
         dly_run_reg <= dly_run_reg + 13'h0001;
      end
   end
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_RST);
   AST_WDG_STARTS: assert property (
      (st_reg == ST_IDLE && I_WDG_RST) |=> (st_reg == ST_ACTIVE && src_reg == SRC_WDG))
      else $error("watchdog did not start the sequence");
   AST_PIN_LOW_IN_DELAY: assert property (
      (st_reg == ST_DELAY) |-> (O_RST_PIN_OE && !O_RST_PIN_O && O_CORE_RST))
      else $error("reset pin not driven low in delay");
   AST_PHASE_ORDER: assert property (
      (st_reg == ST_FETCH && $past(st_reg) != ST_FETCH) |-> $past(st_reg) == ST_DELAY)
      else $error("fetch not entered from delay");
   AST_DELAY_LENGTH: assert property (
      (st_reg == ST_FETCH && $past(st_reg) == ST_DELAY) |-> dly_run_reg == dly_len)
      else $error("delay length wrong");
   AST_FETCH_TWO: assert property (
      $rose(vec_fetch_reg) |-> vec_fetch_reg[*2] ##1 (!vec_fetch_reg || st_reg == ST_ACTIVE))
      else $error("fetch phase not two cycles");
   AST_VECTOR_ADDR: assert property (
      $rose(O_VEC_FETCH) && !restart |-> O_VEC_ADDR == VEC_LO ##1 O_VEC_ADDR == VEC_HI)
      else $error("vector address sequence wrong");
   AST_EXT_NOT_DRIVEN: assert property (
      (st_reg == ST_ACTIVE && src_reg == SRC_EXT) |-> !O_RST_PIN_OE)
      else $error("pin driven while outside holds it");
   AST_PIN_LATCHED: assert property (
      (!I_RST_PIN_I && st_reg == ST_IDLE && guard_reg == '0) |-> ##3 (st_reg == ST_ACTIVE
      || !$past(ext_latch_reg, 2) || $past(I_RST_PIN_I, 3)))
      else $error("low pin did not start reset");
   AST_LEVEL_READ: assert property (
      (setup_rd && off == OFF_SYSTEM_INTEGRITY_CTRL_STATUS) |=> O_PRDATA[SI_LEVEL_BIT] == $past(cmp_sync & opt_lsd_reg))
      else $error("level bit read wrong");
   AST_MONITOR_OFF: assert property (
      !opt_lsd_reg |-> (!aux_ev && !cmp_change && !system_integrity_ctrl_status_val[SI_LEVEL_BIT]))
      else $error("aux monitor active while disabled");
   AST_FLAG_TOGGLES: assert property (
      cmp_change |=> (flag_reg != $past(flag_reg)))
      else $error("flag did not toggle");
   AST_NO_EVENT_IN_SEQ: assert property (
      (st_reg != ST_IDLE && !en_rise) |-> !aux_ev)
      else $error("aux event during reset sequence");
   AST_ENABLE_IRQ: assert property (
      (en_rise && opt_lsd_reg) |=> stat_reg[IRQ_AUX_BIT])
      else $error("enable gave no interrupt");
   AST_CROSS_IRQ: assert property (
      (cmp_change && irq_en_reg) |=> stat_reg[IRQ_AUX_BIT])
      else $error("crossing gave no interrupt");
   AST_TOOL_PINS: assert property (
      tool_sync |-> !O_INCIRCUIT_PINS_APP_EN)
      else $error("pins given to application with tool attached");
   AST_RESTART: assert property (
      (st_reg != ST_IDLE && I_WDG_RST) |=> (st_reg == ST_ACTIVE && cnt_reg == '0))
      else $error("sequence did not restart");
endmodule : rssw_reset_seq

// ==== logic/rssw_sync2.sv ====
`timescale 1ns/100ps
module rssw_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // levels
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   import rssw_pkg::*;
   logic [W-1:0] meta_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_reg <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule : rssw_sync2
